/* File: encoder_capture_and_shortcut_params.sv */
// Our own choices: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// R1 - marker sets flag only when enabled
// R2 - software writes zero to re-arm
// R3 - software writing one is ignored
// R4 - source codes: drive, slots, user, unconfigured
// R5 - freeze sets flag only when enabled
// R6 - trip 81 loads error identifier
// R7 - error codes zero to four
// R8 - shortcut bits zero to four assigned
// R9 - setpoint forwarded only when enabled
// R10 - speed mirrored to preset every 250us
// R11 - drive must select preset speed one
// R12 - hard speed forwarded every 250us
// R13 - hard speed only in closed loop
// R14 - freeze captures turns high, position low
// R15 - marker captures reference position
// R16 - reserved shortcut bits read zero
module encoder_capture_and_shortcut_params
  import enc_param_pkg::*;
#(
  parameter int FWD_CYCLES = FWD_PERIOD_CYCLES
)
(
  // System
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // Encoder inputs
  input  wire logic [15:0] ref_turns_i,
  input  wire logic [15:0] ref_coarse_pos_i,
  input  wire logic [15:0] fbk_turns_i,
  input  wire logic [15:0] fbk_coarse_pos_i,
  input  wire logic        ref_marker_i,
  input  wire logic        fbk_marker_i,
  input  wire logic        ref_freeze_i,
  input  wire logic        fbk_freeze_i,
  // Position control library trip
  input  wire logic        motion_trip_i,
  input  wire logic [31:0] motion_error_code_i,
  // Drive side
  output logic [31:0]      preset_speed_one_o,
  output logic             preset_speed_one_load_o,
  output logic [31:0]      drive_hard_speed_ref_o,
  output logic             drive_hard_speed_load_o,
  output logic [7:0]       shortcut_enables_o,
  output logic [7:0]       ref_source_sel_o,
  output logic [7:0]       fbk_source_sel_o,
  // Interrupt
  output logic             irq_o
);

  // Register state
  logic [7:0]           ref_source_sel_ff;
  logic [7:0]           fbk_source_sel_ff;
  logic [3:0]           enables_ff;
  logic [31:0]          motion_error_id_ff;
  logic [7:0]           shortcut_enables_ff;
  logic [31:0]          speed_setpoint_fine_ff;
  logic [31:0]          hard_speed_setpoint_ff;
  logic [IRQ_WIDTH-1:0] irq_status_ff;
  logic [IRQ_WIDTH-1:0] irq_mask_ff;
  // Drive-side copies and bus answer
  logic [31:0]          preset_speed_one_ff;
  logic [31:0]          drive_hard_speed_ref_ff;
  logic                 speed_load_ff;
  logic                 hard_load_ff;
  logic                 ack_ff;
  logic                 err_ff;
  logic [31:0]          rdata_ff;

  // Bus decode
  wire logic req_w   = wb_cyc_i & wb_stb_i & ~ack_ff & ~err_ff;
  wire logic wr_w    = req_w & wb_we_i & ce_i;
  wire logic rd_w    = req_w & ~wb_we_i & ce_i;

  // Address hits
  wire logic hit_flags    = (wb_adr_i == REG_FLAGS_OFS);
  wire logic hit_ref_src  = (wb_adr_i == REG_REF_SRC_OFS);
  wire logic hit_fbk_src  = (wb_adr_i == REG_FBK_SRC_OFS);
  wire logic hit_enables  = (wb_adr_i == REG_ENABLES_OFS);
  wire logic hit_err_id   = (wb_adr_i == REG_ERROR_ID_OFS);
  wire logic hit_shortcut = (wb_adr_i == REG_SHORTCUT_OFS);
  wire logic hit_speed    = (wb_adr_i == REG_SPEED_OFS);
  wire logic hit_hard     = (wb_adr_i == REG_HARD_SPEED_OFS);
  wire logic hit_frz_ref  = (wb_adr_i == REG_FRZ_REF_OFS);
  wire logic hit_frz_fbk  = (wb_adr_i == REG_FRZ_FBK_OFS);
  wire logic hit_mrk_ref  = (wb_adr_i == REG_MRK_REF_OFS);
  wire logic hit_irq_stat = (wb_adr_i == REG_IRQ_STAT_OFS);
  wire logic hit_irq_mask = (wb_adr_i == REG_IRQ_MASK_OFS);
  wire logic mapped_w = hit_flags | hit_ref_src | hit_fbk_src | hit_enables | hit_err_id
                      | hit_shortcut | hit_speed | hit_hard | hit_frz_ref | hit_frz_fbk
                      | hit_mrk_ref | hit_irq_stat | hit_irq_mask;

  // Byte-lane merge
  function automatic logic [31:0] merge_bytes(input logic [31:0] cur, input logic [31:0] wd,
                                              input logic [3:0] sel);
    logic [31:0] res;
    res = cur;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        res[i*8 +: 8] = wd[i*8 +: 8];
    merge_bytes = res;
  endfunction : merge_bytes

  // Flags register: a write of zero to a bit clears it, a one is ignored
  wire logic       flags_wr_w = wr_w & hit_flags & wb_sel_i[0];
  wire logic [3:0] flag_clr_w = {4{flags_wr_w}} & ~wb_dat_i[3:0]; // R2 R3

  // Capture channels
  logic        ref_marker_flag;
  logic        fbk_marker_flag;
  logic        ref_freeze_flag;
  logic        fbk_freeze_flag;
  logic        ref_marker_set;
  logic        fbk_marker_set;
  logic        ref_freeze_set;
  logic        fbk_freeze_set;
  logic [31:0] ref_marker_pos;
  logic [31:0] ref_freeze_word;
  logic [31:0] fbk_freeze_word;
  wire  logic [31:0] ref_pos_w = {ref_turns_i, ref_coarse_pos_i}; // R14
  wire  logic [31:0] fbk_pos_w = {fbk_turns_i, fbk_coarse_pos_i}; // R14

  // Reference marker and its position word
  enc_capture u_ref_marker (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .position_i  (ref_pos_w),
    .event_i     (ref_marker_i),
    .enable_i    (enables_ff[EN_REF_MARKER_BIT]), // R1
    .clear_i     (flag_clr_w[FLG_REF_MARKER_BIT]),
    .flag_o      (ref_marker_flag),
    .set_pulse_o (ref_marker_set),
    .capture_o   (ref_marker_pos) // R15
  );

  // Feedback marker, flag only
  enc_capture u_fbk_marker (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .position_i  (fbk_pos_w),
    .event_i     (fbk_marker_i),
    .enable_i    (enables_ff[EN_FBK_MARKER_BIT]), // R1
    .clear_i     (flag_clr_w[FLG_FBK_MARKER_BIT]),
    .flag_o      (fbk_marker_flag),
    .set_pulse_o (fbk_marker_set),
    .capture_o   ()
  );

  // Reference freeze word
  enc_capture u_ref_freeze (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .position_i  (ref_pos_w),
    .event_i     (ref_freeze_i),
    .enable_i    (enables_ff[EN_REF_FREEZE_BIT]), // R5
    .clear_i     (flag_clr_w[FLG_REF_FREEZE_BIT]),
    .flag_o      (ref_freeze_flag),
    .set_pulse_o (ref_freeze_set),
    .capture_o   (ref_freeze_word)
  );

  // Feedback freeze word
  enc_capture u_fbk_freeze (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .position_i  (fbk_pos_w),
    .event_i     (fbk_freeze_i),
    .enable_i    (enables_ff[EN_FBK_FREEZE_BIT]), // R5
    .clear_i     (flag_clr_w[FLG_FBK_FREEZE_BIT]),
    .flag_o      (fbk_freeze_flag),
    .set_pulse_o (fbk_freeze_set),
    .capture_o   (fbk_freeze_word)
  );

  // Forwarding tick
  logic fwd_tick;

  fwd_timer #(
    .PERIOD_CYCLES (FWD_CYCLES)
  ) u_fwd_timer (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .tick_o (fwd_tick)
  );

  wire logic speed_fwd_w = fwd_tick & shortcut_enables_ff[SC_SPEED_BIT];      // R9 R10
  wire logic hard_fwd_w  = fwd_tick & shortcut_enables_ff[SC_HARD_SPEED_BIT]; // R9 R12

  // Interrupt events and read-to-clear
  wire logic [IRQ_WIDTH-1:0] irq_event_w = {motion_trip_i & ce_i, fbk_freeze_set,
                                            ref_freeze_set, fbk_marker_set, ref_marker_set};
  wire logic stat_rd_w = rd_w & hit_irq_stat;

  // Register write data
  wire logic [31:0] err_id_nxt_w = motion_error_code_i; // R7
  wire logic [31:0] shortcut_merge_w = merge_bytes({24'h000000, shortcut_enables_ff},
                                                   wb_dat_i, wb_sel_i);
  wire logic [7:0] nxt_shortcut = shortcut_merge_w[7:0] & SC_WRITABLE_MASK; // R8 R16

  // Software-written registers

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ref_source_sel_ff      <= SOURCE_RESET;
      fbk_source_sel_ff      <= SOURCE_RESET;
      enables_ff             <= 4'h0;
      shortcut_enables_ff    <= SHORTCUT_RESET;
      speed_setpoint_fine_ff <= WORD_RESET;
      hard_speed_setpoint_ff <= WORD_RESET;
      irq_mask_ff            <= '0;
    end
    else if (wr_w)
    begin
      if (hit_ref_src && wb_sel_i[0])
        ref_source_sel_ff <= wb_dat_i[7:0]; // R4
      if (hit_fbk_src && wb_sel_i[0])
        fbk_source_sel_ff <= wb_dat_i[7:0]; // R4
      if (hit_enables && wb_sel_i[0])
        enables_ff <= wb_dat_i[3:0];
      if (hit_shortcut)
        shortcut_enables_ff <= nxt_shortcut; // R16
      if (hit_speed)
        speed_setpoint_fine_ff <= merge_bytes(speed_setpoint_fine_ff, wb_dat_i, wb_sel_i);
      if (hit_hard)
        hard_speed_setpoint_ff <= merge_bytes(hard_speed_setpoint_ff, wb_dat_i, wb_sel_i);
      if (hit_irq_mask && wb_sel_i[0])
        irq_mask_ff <= wb_dat_i[IRQ_WIDTH-1:0];
    end
  end

  // Error identifier and sticky interrupt status
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      motion_error_id_ff <= ERROR_ID_RESET;
      irq_status_ff      <= '0;
    end
    else if (ce_i)
    begin
      // Code only valid while the trip is raised
      if (motion_trip_i)
        motion_error_id_ff <= err_id_nxt_w; // R6
      // New events win over a same-cycle status read
      irq_status_ff <= irq_event_w | (irq_status_ff & ~{IRQ_WIDTH{stat_rd_w}});
    end
  end

  // Drive forwarding
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      preset_speed_one_ff     <= WORD_RESET;
      drive_hard_speed_ref_ff <= WORD_RESET;
      speed_load_ff           <= 1'b0;
      hard_load_ff            <= 1'b0;
    end
    else if (ce_i)
    begin
      // Load strobes lag the tick by one cycle
      speed_load_ff <= speed_fwd_w; // R10
      hard_load_ff  <= hard_fwd_w; // R12
      if (speed_fwd_w)
        preset_speed_one_ff <= speed_setpoint_fine_ff; // R10
      if (hard_fwd_w)
        drive_hard_speed_ref_ff <= hard_speed_setpoint_ff; // R12
    end
  end

  // Read mux
  wire logic [31:0] flags_rd_w = {28'h0000000, fbk_freeze_flag, ref_freeze_flag,
                                  fbk_marker_flag, ref_marker_flag};
  // Priority chain; hits are mutually exclusive
  wire logic [31:0] rd_mux_w =
      hit_flags    ? flags_rd_w :
      hit_ref_src  ? {24'h000000, ref_source_sel_ff} :
      hit_fbk_src  ? {24'h000000, fbk_source_sel_ff} :
      hit_enables  ? {28'h0000000, enables_ff} :
      hit_err_id   ? motion_error_id_ff :
      hit_shortcut ? {24'h000000, shortcut_enables_ff} :
      hit_speed    ? speed_setpoint_fine_ff :
      hit_hard     ? hard_speed_setpoint_ff :
      hit_frz_ref  ? ref_freeze_word :
      hit_frz_fbk  ? fbk_freeze_word :
      hit_mrk_ref  ? ref_marker_pos :
      hit_irq_stat ? {27'h0000000, irq_status_ff} :
      hit_irq_mask ? {27'h0000000, irq_mask_ff} :
                     32'h0000_0000;

  // Bus answer one cycle after the request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff   <= 1'b0;
      err_ff   <= 1'b0;
      rdata_ff <= WORD_RESET;
    end
    else
    begin
      // Ack and err are single-cycle pulses
      ack_ff <= req_w & ce_i & mapped_w;
      err_ff <= req_w & ce_i & ~mapped_w;
      if (rd_w)
        rdata_ff <= rd_mux_w;
    end
  end

  // Outputs
  assign wb_dat_o                = rdata_ff;
  assign wb_ack_o                = ack_ff;
  assign wb_err_o                = err_ff;
  assign preset_speed_one_o      = preset_speed_one_ff;
  assign preset_speed_one_load_o = speed_load_ff;
  assign drive_hard_speed_ref_o  = drive_hard_speed_ref_ff;
  assign drive_hard_speed_load_o = hard_load_ff;
  assign shortcut_enables_o      = shortcut_enables_ff;
  assign ref_source_sel_o        = ref_source_sel_ff;
  assign fbk_source_sel_o        = fbk_source_sel_ff;
  assign irq_o                   = |(irq_status_ff & irq_mask_ff);

endmodule : encoder_capture_and_shortcut_params
`default_nettype wire

/* File: enc_param_pkg.sv */
`default_nettype none
package enc_param_pkg;

  // Register byte addresses
  localparam logic [7:0] REG_FLAGS_OFS      = 8'h00;
  localparam logic [7:0] REG_REF_SRC_OFS    = 8'h04;
  localparam logic [7:0] REG_FBK_SRC_OFS    = 8'h08;
  localparam logic [7:0] REG_ENABLES_OFS    = 8'h0C;
  localparam logic [7:0] REG_ERROR_ID_OFS   = 8'h10;
  localparam logic [7:0] REG_SHORTCUT_OFS   = 8'h14;
  localparam logic [7:0] REG_SPEED_OFS      = 8'h18;
  localparam logic [7:0] REG_HARD_SPEED_OFS = 8'h1C;
  localparam logic [7:0] REG_FRZ_REF_OFS    = 8'h20;
  localparam logic [7:0] REG_FRZ_FBK_OFS    = 8'h24;
  localparam logic [7:0] REG_MRK_REF_OFS    = 8'h28;
  localparam logic [7:0] REG_IRQ_STAT_OFS   = 8'h2C;
  localparam logic [7:0] REG_IRQ_MASK_OFS   = 8'h30;

  // Flag register bits
  localparam int FLG_REF_MARKER_BIT = 0;
  localparam int FLG_FBK_MARKER_BIT = 1;
  localparam int FLG_REF_FREEZE_BIT = 2;
  localparam int FLG_FBK_FREEZE_BIT = 3;

  // Enable register bits
  localparam int EN_REF_MARKER_BIT = 0;
  localparam int EN_FBK_MARKER_BIT = 1;
  localparam int EN_REF_FREEZE_BIT = 2;
  localparam int EN_FBK_FREEZE_BIT = 3;

  // Interrupt status bits
  localparam int IRQ_REF_MARKER_BIT = 0;
  localparam int IRQ_FBK_MARKER_BIT = 1;
  localparam int IRQ_REF_FREEZE_BIT = 2;
  localparam int IRQ_FBK_FREEZE_BIT = 3;
  localparam int IRQ_MOTION_TRIP_BIT = 4;
  localparam int IRQ_WIDTH = 5;

  // Shortcut enable bits
  localparam int SC_SPEED_BIT      = 0;
  localparam int SC_HARD_SPEED_BIT = 1;
  localparam int SC_TORQUE_BIT     = 2;
  localparam int SC_ANALOG1_BIT    = 3;
  localparam int SC_ANALOG2_BIT    = 4;
  localparam logic [7:0] SC_WRITABLE_MASK = 8'h1F;

  // Reset values
  localparam logic [7:0] SHORTCUT_RESET   = 8'h00;
  localparam logic [7:0] SOURCE_RESET     = 8'h05;
  localparam logic [31:0] WORD_RESET      = 32'h0000_0000;
  localparam logic [31:0] ERROR_ID_RESET  = 32'h0000_0000;

  // Encoder sources
  typedef enum logic [7:0] {
    SRC_DRIVE_ENCODER = 8'h00,
    SRC_SLOT_ONE      = 8'h01,
    SRC_SLOT_TWO      = 8'h02,
    SRC_SLOT_THREE    = 8'h03,
    SRC_USER_PROGRAM  = 8'h04,
    SRC_UNCONFIGURED  = 8'h05
  } enc_source_t;

  // Motion error identifiers
  typedef enum logic [31:0] {
    ERR_NONE_OR_ENC_SETUP = 32'h0000_0000,
    ERR_CAM_ARRAY_SMALL   = 32'h0000_0001,
    ERR_CAM_SEG_OVERRUN   = 32'h0000_0002,
    ERR_CAM_SIZE_ZERO     = 32'h0000_0003,
    ERR_CAM_ABS_RESET     = 32'h0000_0004
  } motion_error_t;

  // Forwarding period
  localparam int CLK_FREQ_HZ        = 125_000_000;
  localparam int FWD_PERIOD_US      = 250;
  localparam int FWD_PERIOD_CYCLES  = (CLK_FREQ_HZ / 1_000_000) * FWD_PERIOD_US;

  // Marker/freeze flag update: set beats software clear
  function automatic logic sticky_next(input logic cur, input logic set_ev,
                                       input logic clr);
    sticky_next = set_ev | (cur & ~clr);
  endfunction : sticky_next

endpackage : enc_param_pkg
`default_nettype wire

/* File: enc_capture.sv */
`timescale 1ns/10ps
`default_nettype none
module enc_capture
  import enc_param_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Encoder side
  input  wire logic [31:0] position_i,
  input  wire logic        event_i,
  input  wire logic        enable_i,
  // Software clear
  input  wire logic        clear_i,
  // Results
  output logic             flag_o,
  output logic             set_pulse_o,
  output logic [31:0]      capture_o
);

  logic        flag_ff;
  logic [31:0] capture_ff;
  wire  logic  take_w = event_i & enable_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flag_ff    <= 1'b0;
      capture_ff <= WORD_RESET;
    end
    else if (ce_i)
    begin
      flag_ff <= sticky_next(flag_ff, take_w, clear_i);
      if (take_w)
        capture_ff <= position_i;
    end
  end

  assign flag_o      = flag_ff;
  assign set_pulse_o = take_w & ce_i;
  assign capture_o   = capture_ff;

endmodule : enc_capture
`default_nettype wire

/* File: fwd_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module fwd_timer
  import enc_param_pkg::*;
#(
  parameter int PERIOD_CYCLES = FWD_PERIOD_CYCLES
)
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  // Tick
  output logic      tick_o
);

  logic [15:0] count_ff;
  wire  logic  wrap_w = (count_ff == 16'(PERIOD_CYCLES - 1));

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count_ff <= 16'h0000;
    else if (ce_i)
      count_ff <= wrap_w ? 16'h0000 : count_ff + 16'h0001;
  end

  assign tick_o = wrap_w & ce_i;

endmodule : fwd_timer
`default_nettype wire

/* File: enc_param_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module enc_param_monitor
  import enc_param_pkg::*;
#(
  parameter int FWD_CYCLES = FWD_PERIOD_CYCLES
)
(
  // System
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  // Register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  // Drive side
  input wire logic        preset_speed_one_load_o,
  input wire logic        drive_hard_speed_load_o,
  input wire logic [7:0]  shortcut_enables_o,
  input wire logic [7:0]  ref_source_sel_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic        req;
  logic        load;
  logic        seen_ff;
  logic [31:0] gap_ff;

  assign req  = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o & ce_i;
  assign load = preset_speed_one_load_o | drive_hard_speed_load_o;

  // Cycles since the last forwarding pulse
  always_ff @(posedge clk_i)
  begin
    gap_ff  <= (rst_i | load) ? 32'h0000_0001 : gap_ff + 32'h0000_0001;
    seen_ff <= ~rst_i & (seen_ff | load);
  end

  ack_latency_a: assert property (req |=> wb_ack_o | wb_err_o)
    else $error("bus request not answered next cycle");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  err_unmapped_a: assert property (req && wb_adr_i > 8'h30 |=> wb_err_o && !wb_ack_o)
    else $error("unmapped address not refused");
  shortcut_write_a: assert property (
    wb_ack_o && wb_we_i && wb_adr_i == REG_SHORTCUT_OFS && wb_sel_i[0]
    |-> shortcut_enables_o == (wb_dat_i[7:0] & SC_WRITABLE_MASK))
    else $error("shortcut enables differ from written value");
  shortcut_rsvd_a: assert property (shortcut_enables_o[7:5] == 3'h0)
    else $error("reserved shortcut bits set");
  source_write_a: assert property (
    wb_ack_o && wb_we_i && wb_adr_i == REG_REF_SRC_OFS && wb_sel_i[0]
    |-> ref_source_sel_o == wb_dat_i[7:0])
    else $error("reference source differs from written value");
  speed_gate_a: assert property (preset_speed_one_load_o |-> $past(shortcut_enables_o[0]))
    else $error("speed forwarded while its shortcut is off");
  hard_gate_a: assert property (drive_hard_speed_load_o |-> $past(shortcut_enables_o[1]))
    else $error("hard speed forwarded while its shortcut is off");
  fwd_period_a: assert property (load && seen_ff |-> (gap_ff % FWD_CYCLES) == 0)
    else $error("forwarding pulse off its period");

  cover property (wb_err_o);
  cover property (preset_speed_one_load_o);
  cover property (drive_hard_speed_load_o);
  cover property (irq_o);
endmodule : enc_param_monitor

bind encoder_capture_and_shortcut_params enc_param_monitor #(.FWD_CYCLES(FWD_CYCLES)) mon (
  .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_ack_o, .wb_err_o, .preset_speed_one_load_o,
  .drive_hard_speed_load_o, .shortcut_enables_o, .ref_source_sel_o, .irq_o
);
`default_nettype wire

/* File: drive_model.sv */
`timescale 1ns/10ps
`default_nettype none
module drive_model
(
  // System
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Bench requests
  input  wire logic [4:0]  ev_req_i,
  input  wire logic [31:0] code_i,
  // Encoders and trip
  output logic [31:0]      ref_pos_o,
  output logic [31:0]      fbk_pos_o,
  output logic [4:0]       ev_o,
  output logic [31:0]      code_o,
  // Setpoints
  input  wire logic [31:0] speed_i,
  input  wire logic        speed_ld_i,
  input  wire logic [31:0] hard_i,
  input  wire logic        hard_ld_i,
  output logic [31:0]      speed_o,
  output logic [31:0]      hard_o,
  output logic [15:0]      loads_o
);
  logic [31:0] code_ff;

  // Code is only meaningful with a trip
  assign code_o = ev_o[4] ? code_ff : ~code_ff;

  always_ff @(posedge clk_i)
  begin
    ev_o    <= rst_i ? 5'h00 : ev_req_i;
    code_ff <= code_i;
    if (rst_i)
    begin
      ref_pos_o <= 32'h0100_0000;
      fbk_pos_o <= 32'h0200_8000;
      speed_o   <= 32'h0000_0000;
      hard_o    <= 32'h0000_0000;
      loads_o   <= 16'h0000;
    end
    else
    begin
      // Both shafts keep turning
      ref_pos_o <= ref_pos_o + 32'h0001_0003;
      fbk_pos_o <= fbk_pos_o + 32'h0002_0007;
      // Preset speed one selected, closed loop mode
      if (speed_ld_i) speed_o <= speed_i;
      if (hard_ld_i) hard_o <= hard_i;
      loads_o <= loads_o + 16'(speed_ld_i) + 16'(hard_ld_i);
    end
  end
endmodule : drive_model
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb
  import enc_param_pkg::*;
;
  localparam int FWD = 20;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [3:0]  lanes = 4'hF;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] code = 32'h0000_0000;
  logic [4:0]  ev_req = 5'h00;
  logic [31:0] wb_dat_o, preset_speed_one_o, drive_hard_speed_ref_o;
  logic        wb_ack_o, wb_err_o, preset_speed_one_load_o, drive_hard_speed_load_o, irq_o;
  logic [7:0]  shortcut_enables_o, ref_source_sel_o, fbk_source_sel_o;
  logic [31:0] ref_pos, fbk_pos, code_o, speed_t, hard_t, exp_rm, exp_rf, exp_ff;
  logic [31:0] rdat, sp, hs, r;
  logic [4:0]  ev;
  logic [15:0] loads, snap;
  logic        erred;
  int          failures = 0;
  int          comparisons = 0;
  int          ticks = 0;
  int          seed;

  always #4 clk_i = ~clk_i;

  encoder_capture_and_shortcut_params #(.FWD_CYCLES(FWD)) uut (
    .clk_i, .rst_i, .ce_i(1'b1), .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
    .ref_turns_i(ref_pos[31:16]), .ref_coarse_pos_i(ref_pos[15:0]),
    .fbk_turns_i(fbk_pos[31:16]), .fbk_coarse_pos_i(fbk_pos[15:0]),
    .ref_marker_i(ev[0]), .fbk_marker_i(ev[1]), .ref_freeze_i(ev[2]),
    .fbk_freeze_i(ev[3]), .motion_trip_i(ev[4]), .motion_error_code_i(code_o),
    .preset_speed_one_o, .preset_speed_one_load_o, .drive_hard_speed_ref_o,
    .drive_hard_speed_load_o, .shortcut_enables_o, .ref_source_sel_o,
    .fbk_source_sel_o, .irq_o
  );

  drive_model far (
    .clk_i, .rst_i, .ev_req_i(ev_req), .code_i(code), .ref_pos_o(ref_pos),
    .fbk_pos_o(fbk_pos), .ev_o(ev), .code_o, .speed_i(preset_speed_one_o),
    .speed_ld_i(preset_speed_one_load_o), .hard_i(drive_hard_speed_ref_o),
    .hard_ld_i(drive_hard_speed_load_o), .speed_o(speed_t), .hard_o(hard_t),
    .loads_o(loads)
  );

  // Position seen at the reference marker and both freeze edges, plus the run limit
  always @(posedge clk_i)
  begin
    ticks++;
    if (ev[0]) exp_rm <= ref_pos;
    if (ev[2]) exp_rf <= ref_pos;
    if (ev[3]) exp_ff <= fbk_pos;
    if (ticks == 10000)
    begin
      failures++;
      close_out();
    end
  end

  function automatic logic [31:0] rst_val(input logic [7:0] a);
    rst_val = (a == REG_REF_SRC_OFS || a == REG_FBK_SRC_OFS) ? {24'h0, SOURCE_RESET} : 32'h0;
  endfunction : rst_val

  function automatic logic [31:0] sc_val(input logic [31:0] d);
    sc_val = {24'h0, d[7:0] & 8'h1F};
  endfunction : sc_val

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_sel_i <= lanes;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    rdat = wb_dat_o;
    erred = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0);
  endtask : rd

  task automatic fire(input logic [4:0] m);
    ev_req <= m;
    @(posedge clk_i);
    ev_req <= 5'h00;
    repeat (3) @(posedge clk_i);
  endtask : fire

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  initial
  begin
    seed = 86;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      rd(8'(4 * i));
      check("reset value", rdat, rst_val(8'(4 * i)));
    end
    rd(8'h34);
    check("unmapped err", {31'h0, erred}, 32'h1);
    for (int v = 0; v < 6; v++)
    begin
      wr(REG_REF_SRC_OFS, 32'(v));
      wr(REG_FBK_SRC_OFS, 32'(5 - v));
      check("ref source", {24'h0, ref_source_sel_o}, 32'(v));
      check("fbk source", {24'h0, fbk_source_sel_o}, 32'(5 - v));
    end
    for (int i = 0; i < 6; i++)
    begin
      r = (i == 0) ? 32'hFF : $random(seed);
      wr(REG_SHORTCUT_OFS, r);
      rd(REG_SHORTCUT_OFS);
      check("shortcut", rdat, sc_val(r));
    end
    wr(REG_IRQ_MASK_OFS, 32'h1F);
    fire(5'h0F);
    rd(REG_FLAGS_OFS);
    check("flags disabled", rdat, 32'h0);
    wr(REG_ENABLES_OFS, 32'hF);
    fire(5'h0F);
    rd(REG_FLAGS_OFS);
    check("flags set", rdat, 32'hF);
    rd(REG_FRZ_REF_OFS);
    check("ref freeze word", rdat, exp_rf);
    rd(REG_FRZ_FBK_OFS);
    check("fbk freeze word", rdat, exp_ff);
    rd(REG_MRK_REF_OFS);
    check("ref marker pos", rdat, exp_rm);
    check("irq raised", {31'h0, irq_o}, 32'h1);
    rd(REG_IRQ_STAT_OFS);
    check("irq status", rdat, 32'hF);
    check("irq cleared", {31'h0, irq_o}, 32'h0);
    wr(REG_FLAGS_OFS, 32'hF);
    rd(REG_FLAGS_OFS);
    check("flags kept", rdat, 32'hF);
    wr(REG_FLAGS_OFS, 32'h0);
    rd(REG_FLAGS_OFS);
    check("flags rearmed", rdat, 32'h0);
    wr(REG_IRQ_MASK_OFS, 32'h0);
    fire(5'h02);
    check("irq masked", {31'h0, irq_o}, 32'h0);
    rd(REG_FLAGS_OFS);
    check("fbk marker only", rdat, 32'h2);
    rd(REG_IRQ_STAT_OFS);
    check("masked status", rdat, 32'h2);
    for (int c = 4; c >= 0; c--)
    begin
      code <= 32'(c);
      fire(5'h10);
      rd(REG_ERROR_ID_OFS);
      check("error id", rdat, 32'(c));
    end
    rd(REG_IRQ_STAT_OFS);
    check("trip status", rdat, 32'h10);
    wr(REG_SHORTCUT_OFS, 32'h0);
    sp = $random(seed);
    hs = $random(seed);
    wr(REG_SPEED_OFS, sp);
    wr(REG_HARD_SPEED_OFS, hs);
    snap = loads;
    repeat (3 * FWD) @(posedge clk_i);
    check("no forwarding", {16'h0, loads}, {16'h0, snap});
    wr(REG_SHORTCUT_OFS, 32'h1);
    repeat (FWD + 2) @(posedge clk_i);
    check("preset speed", speed_t, sp);
    check("hard gated", hard_t, 32'h0);
    wr(REG_SHORTCUT_OFS, 32'h2);
    repeat (FWD + 2) @(posedge clk_i);
    check("hard speed", hard_t, hs);
    lanes = 4'h2;
    wr(REG_SPEED_OFS, ~sp);
    lanes = 4'hF;
    rd(REG_SPEED_OFS);
    check("speed lane merge", rdat, {sp[31:16], ~sp[15:8], sp[7:0]});
    close_out();
  end
endmodule : tb
`default_nettype wire
